//--- rtl/slac_pkg.sv
// Package of offsets, field positions and reset values for the lane analog configuration bank
package slac_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAC_OFS_RX0  = 8'h04;
  localparam logic [7:0] SLAC_OFS_RX1  = 8'h08;
  localparam logic [7:0] SLAC_OFS_TX0  = 8'h0c;
  localparam logic [7:0] SLAC_OFS_TX1  = 8'h10;
  localparam logic [7:0] SLAC_OFS_SER  = 8'h14;
  localparam logic [7:0] SLAC_OFS_COM  = 8'h18;
  localparam logic [7:0] SLAC_OFS_PLL  = 8'h1c;
  // ----------------------------------------------------------------
  // Implemented bit masks
  // ----------------------------------------------------------------
  localparam logic [31:0] SLAC_MSK_RX0 = 32'h0fff_ffff;
  localparam logic [31:0] SLAC_MSK_RX1 = 32'h0000_3fbf;
  localparam logic [31:0] SLAC_MSK_TX0 = 32'hffff_ffff;
  localparam logic [31:0] SLAC_MSK_TX1 = 32'h0000_01ff;
  localparam logic [31:0] SLAC_MSK_SER = 32'h0000_01ff;
  localparam logic [31:0] SLAC_MSK_COM = 32'h8004_fff0;
  localparam logic [31:0] SLAC_MSK_PLL = 32'h0015_ffee;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SLAC_RST_RX0 = 32'h0000_0000;
  localparam logic [31:0] SLAC_RST_RX1 = 32'h0000_0000;
  localparam logic [31:0] SLAC_RST_TX0 = 32'h0000_0000;
  localparam logic [31:0] SLAC_RST_TX1 = 32'h0000_0000;
  localparam logic [31:0] SLAC_RST_SER = 32'h0000_0000;
  localparam logic [31:0] SLAC_RST_COM = 32'h0000_0090;
  localparam logic [31:0] SLAC_RST_PLL = 32'h0004_0002;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLAC_RX_THR_LSB    = 4;
  localparam int SLAC_RX_TRIM_LSB   = 0;
  localparam int SLAC_RX_CTERM_BIT  = 5;
  localparam int SLAC_RX_ONE_BIT    = 4;
  localparam int SLAC_RX_OFSAC_BIT  = 3;
  localparam int SLAC_RX_OFSDC_BIT  = 2;
  localparam int SLAC_RX_SLOW_BIT   = 1;
  localparam int SLAC_TX_IDLE_BIT   = 31;
  localparam int SLAC_TX_SUPPLY_BIT = 30;
  localparam int SLAC_TX_POL_BIT    = 29;
  localparam int SLAC_TX_POST0_LSB  = 23;
  localparam int SLAC_TX_POST1_LSB  = 18;
  localparam int SLAC_TX_PREC_LSB   = 13;
  localparam int SLAC_TX_SRH_BIT    = 8;
  localparam int SLAC_TX_TRIM_LSB   = 4;
  localparam int SLAC_TX_SR_LSB     = 0;
  localparam int SLAC_TX_SKEW_LSB   = 6;
  localparam int SLAC_TX_LEV_LSB    = 0;
  localparam int SLAC_SER_HYS_BIT   = 3;
  localparam int SLAC_SER_WIN_BIT   = 1;
  localparam int SLAC_SER_ALI_BIT   = 0;
  localparam int SLAC_COM_RSTN_BIT  = 31;
  localparam int SLAC_COM_LANE_BIT  = 18;
  localparam int SLAC_COM_ELOOP_BIT = 11;
  localparam int SLAC_COM_FLOOP_BIT = 10;
  localparam int SLAC_COM_HALF_RATE_EN_BIT = 7;
  localparam int SLAC_COM_QUARTER_RATE_EN_BIT = 6;
  localparam int SLAC_COM_WIDTH_LSB = 4;
  localparam int SLAC_PLL_ROT_BIT   = 18;
  localparam int SLAC_PLL_WORD_LSB  = 8;
  localparam int SLAC_PLL_FSM_BIT   = 7;
  localparam int SLAC_PLL_DIR_BIT   = 2;
  localparam int SLAC_PLL_FRQ_BIT   = 1;
endpackage

//--- rtl/slac_bank.sv
// Lane analog configuration register bank
`timescale 1ns/1ns
`default_nettype none
module slac_bank (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic        wr_en_in,
  input  wire logic [31:0] wr_data_in,
  output logic      [31:0] rd_data_out,
  output logic      [3:0]  rx_resistor_trim_out,
  output logic      [2:0]  rx_level_threshold_out,
  output logic             rx_must_be_one_bit_out,
  output logic             rx_common_mode_term_en_out,
  output logic             rx_ac_offset_comp_en_out,
  output logic             rx_dc_offset_comp_en_out,
  output logic             rx_slow_level_detect_en_out,
  output logic             tx_force_idle_out,
  output logic             tx_nominal_supply_sel_out,
  output logic             tx_polarity_invert_out,
  output logic      [5:0]  tx_first_post_cursor_out,
  output logic      [4:0]  tx_second_post_cursor_out,
  output logic      [4:0]  tx_pre_cursor_out,
  output logic             tx_slew_coarse_half_out,
  output logic      [3:0]  tx_resistor_trim_out,
  output logic      [3:0]  tx_slew_fine_out,
  output logic      [2:0]  tx_skew_adjust_out,
  output logic      [5:0]  tx_amplitude_level_out,
  output logic             align_hysteresis_en_out,
  output logic             align_window_en_out,
  output logic             align_en_out,
  output logic             lane_reset_n_out,
  output logic             lane_en_out,
  output logic             equipment_loopback_en_out,
  output logic             facility_loopback_en_out,
  output logic             half_rate_en_out,
  output logic             quarter_rate_en_out,
  output logic      [1:0]  if_width_out,
  output logic             pll_rotation_en_out,
  output logic      [7:0]  pll_fsm_control_word_out,
  output logic             pll_fsm_en_out,
  output logic             pll_rotation_direction_out,
  output logic             pll_rotation_frequency_out
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  localparam int NREG = 7;
  localparam logic [7:0] OFS [NREG] = '{slac_pkg::SLAC_OFS_RX0, slac_pkg::SLAC_OFS_RX1,
    slac_pkg::SLAC_OFS_TX0, slac_pkg::SLAC_OFS_TX1, slac_pkg::SLAC_OFS_SER,
    slac_pkg::SLAC_OFS_COM, slac_pkg::SLAC_OFS_PLL};
  localparam logic [31:0] MSK [NREG] = '{slac_pkg::SLAC_MSK_RX0, slac_pkg::SLAC_MSK_RX1,
    slac_pkg::SLAC_MSK_TX0, slac_pkg::SLAC_MSK_TX1, slac_pkg::SLAC_MSK_SER,
    slac_pkg::SLAC_MSK_COM, slac_pkg::SLAC_MSK_PLL};
  localparam logic [31:0] RST [NREG] = '{slac_pkg::SLAC_RST_RX0, slac_pkg::SLAC_RST_RX1,
    slac_pkg::SLAC_RST_TX0, slac_pkg::SLAC_RST_TX1, slac_pkg::SLAC_RST_SER,
    slac_pkg::SLAC_RST_COM, slac_pkg::SLAC_RST_PLL};

  logic [31:0] reg_q [NREG];

  // Offset match for one register slot
  function automatic logic addr_hit(input logic [7:0] addr, input int idx);
    return addr == OFS[idx];
  endfunction

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      // Plain read-write storage
      always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
          reg_q[g] <= RST[g];
        end else if (wr_en_in && addr_hit(addr_in, g)) begin
          reg_q[g] <= wr_data_in & MSK[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= 32'h0000_0000;
      for (int i = 0; i < NREG; i++) begin
        if (addr_hit(addr_in, i)) begin
          rd_data_out <= reg_q[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_comb begin
    rx_level_threshold_out      = reg_q[0][slac_pkg::SLAC_RX_THR_LSB +: 3];
    rx_resistor_trim_out        = reg_q[0][slac_pkg::SLAC_RX_TRIM_LSB +: 4];
    rx_common_mode_term_en_out  = reg_q[1][slac_pkg::SLAC_RX_CTERM_BIT];
    rx_must_be_one_bit_out      = reg_q[1][slac_pkg::SLAC_RX_ONE_BIT];
    rx_ac_offset_comp_en_out    = reg_q[1][slac_pkg::SLAC_RX_OFSAC_BIT];
    rx_dc_offset_comp_en_out    = reg_q[1][slac_pkg::SLAC_RX_OFSDC_BIT];
    rx_slow_level_detect_en_out = reg_q[1][slac_pkg::SLAC_RX_SLOW_BIT];
    tx_force_idle_out           = reg_q[2][slac_pkg::SLAC_TX_IDLE_BIT];
    tx_nominal_supply_sel_out   = reg_q[2][slac_pkg::SLAC_TX_SUPPLY_BIT];
    tx_polarity_invert_out      = reg_q[2][slac_pkg::SLAC_TX_POL_BIT];
    tx_first_post_cursor_out    = reg_q[2][slac_pkg::SLAC_TX_POST0_LSB +: 6];
    tx_second_post_cursor_out   = reg_q[2][slac_pkg::SLAC_TX_POST1_LSB +: 5];
    tx_pre_cursor_out           = reg_q[2][slac_pkg::SLAC_TX_PREC_LSB +: 5];
    tx_slew_coarse_half_out     = reg_q[2][slac_pkg::SLAC_TX_SRH_BIT];
    tx_resistor_trim_out        = reg_q[2][slac_pkg::SLAC_TX_TRIM_LSB +: 4];
    tx_slew_fine_out            = reg_q[2][slac_pkg::SLAC_TX_SR_LSB +: 4];
    tx_skew_adjust_out          = reg_q[3][slac_pkg::SLAC_TX_SKEW_LSB +: 3];
    tx_amplitude_level_out      = reg_q[3][slac_pkg::SLAC_TX_LEV_LSB +: 6];
    align_hysteresis_en_out     = reg_q[4][slac_pkg::SLAC_SER_HYS_BIT];
    align_window_en_out         = reg_q[4][slac_pkg::SLAC_SER_WIN_BIT];
    align_en_out                = reg_q[4][slac_pkg::SLAC_SER_ALI_BIT];
    lane_reset_n_out            = reg_q[5][slac_pkg::SLAC_COM_RSTN_BIT];
    lane_en_out                 = reg_q[5][slac_pkg::SLAC_COM_LANE_BIT];
    equipment_loopback_en_out   = reg_q[5][slac_pkg::SLAC_COM_ELOOP_BIT];
    facility_loopback_en_out    = reg_q[5][slac_pkg::SLAC_COM_FLOOP_BIT];
    half_rate_en_out            = reg_q[5][slac_pkg::SLAC_COM_HALF_RATE_EN_BIT];
    quarter_rate_en_out         = reg_q[5][slac_pkg::SLAC_COM_QUARTER_RATE_EN_BIT];
    if_width_out                = reg_q[5][slac_pkg::SLAC_COM_WIDTH_LSB +: 2];
    pll_rotation_en_out         = reg_q[6][slac_pkg::SLAC_PLL_ROT_BIT];
    pll_fsm_control_word_out    = reg_q[6][slac_pkg::SLAC_PLL_WORD_LSB +: 8];
    pll_fsm_en_out              = reg_q[6][slac_pkg::SLAC_PLL_FSM_BIT];
    pll_rotation_direction_out  = reg_q[6][slac_pkg::SLAC_PLL_DIR_BIT];
    pll_rotation_frequency_out  = reg_q[6][slac_pkg::SLAC_PLL_FRQ_BIT];
  end
endmodule // slac_bank
`default_nettype wire

//--- dv/slac_bank_checker.sv
// Port checker for the lane analog configuration bank
`timescale 1ns/1ns
`default_nettype none
module slac_bank_checker (
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic [7:0]  addr_in,
  input wire logic        wr_en_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [31:0] rd_data_out,
  input wire logic        tx_force_idle_out,
  input wire logic [5:0]  tx_amplitude_level_out,
  input wire logic        lane_reset_n_out,
  input wire logic        lane_en_out,
  input wire logic        half_rate_en_out,
  input wire logic        pll_rotation_en_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_com_wr; wr_en_in && addr_in == slac_pkg::SLAC_OFS_COM; endsequence
  sequence s_com_rd; !wr_en_in && addr_in == slac_pkg::SLAC_OFS_COM; endsequence
  property p_readback;
    s_com_wr ##1 s_com_rd |=> rd_data_out == ($past(wr_data_in, 2) & slac_pkg::SLAC_MSK_COM);
  endproperty
  property p_unmapped;
    addr_in < 8'h04 || addr_in > 8'h1c || addr_in[1:0] != 2'h0 |=> rd_data_out == 32'h0;
  endproperty
  property p_defaults;
    $fell(reset_in) |-> !lane_reset_n_out && half_rate_en_out && pll_rotation_en_out;
  endproperty
  property p_lane_rst; s_com_wr |=> lane_reset_n_out == $past(wr_data_in[31]); endproperty
  property p_lane_en; s_com_wr |=> lane_en_out == $past(wr_data_in[18]); endproperty
  property p_idle;
    wr_en_in && addr_in == slac_pkg::SLAC_OFS_TX0 |=> tx_force_idle_out == $past(wr_data_in[31]);
  endproperty
  property p_level;
    wr_en_in && addr_in == slac_pkg::SLAC_OFS_TX1 ##1 1'b1
      |-> tx_amplitude_level_out == $past(wr_data_in[5:0]);
  endproperty
  property p_rot_hold;
    !(wr_en_in && addr_in == slac_pkg::SLAC_OFS_PLL) |=> $stable(pll_rotation_en_out);
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_defaults: assert property (p_defaults) else $error("bad reset values");
  a_lane_rst: assert property (p_lane_rst) else $error("lane reset not written");
  a_lane_en: assert property (p_lane_en) else $error("lane enable not written");
  a_idle: assert property (p_idle) else $error("idle not written");
  a_level: assert property (p_level) else $error("amplitude not written");
  a_rot_hold: assert property (p_rot_hold) else $error("rotation moved");
endmodule // slac_bank_checker
bind slac_bank slac_bank_checker slac_bank_checker_inst (.*);
`default_nettype wire

//--- dv/tb_slac_bank.sv
// Self-checking bench for the lane analog configuration bank
`timescale 1ns/1ns
`default_nettype none
module tb_slac_bank;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, wr_en_in = 1'b0;
  logic [7:0] addr_in = 8'h00, pll_fsm_control_word_out;
  logic [31:0] wr_data_in = 32'h0, rd_data_out, got;
  logic [3:0] rx_resistor_trim_out, tx_resistor_trim_out, tx_slew_fine_out;
  logic [2:0] rx_level_threshold_out, tx_skew_adjust_out;
  logic [5:0] tx_first_post_cursor_out, tx_amplitude_level_out;
  logic [4:0] tx_second_post_cursor_out, tx_pre_cursor_out;
  logic [1:0] if_width_out;
  logic rx_must_be_one_bit_out, rx_common_mode_term_en_out, rx_ac_offset_comp_en_out;
  logic rx_dc_offset_comp_en_out, rx_slow_level_detect_en_out, tx_force_idle_out;
  logic tx_nominal_supply_sel_out, tx_polarity_invert_out, tx_slew_coarse_half_out;
  logic align_hysteresis_en_out, align_window_en_out, align_en_out, lane_reset_n_out;
  logic lane_en_out, equipment_loopback_en_out, facility_loopback_en_out, half_rate_en_out;
  logic quarter_rate_en_out, pll_rotation_en_out, pll_fsm_en_out;
  logic pll_rotation_direction_out, pll_rotation_frequency_out;
  int mismatches = 0, n_checks = 0, cyc = 0;
  logic meas_busy = 1'b1;
  localparam logic [3:0] MEAS_CODE = 4'h9; // Arbitrary measured trim code
  logic [31:0] dflt [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h90, 32'h40002};
  logic [31:0] msk [7] = '{slac_pkg::SLAC_MSK_RX0, slac_pkg::SLAC_MSK_RX1,
    slac_pkg::SLAC_MSK_TX0, slac_pkg::SLAC_MSK_TX1, slac_pkg::SLAC_MSK_SER,
    slac_pkg::SLAC_MSK_COM, slac_pkg::SLAC_MSK_PLL};
  logic [31:0] omsk [7] = '{32'h7f, 32'h3e, 32'hffffe1ff, 32'h1ff, 32'hb, 32'h80040cf0,
    32'h4ff86};
  logic [31:0] pat [4] = '{32'hffffffff, 32'h5a5a5a5b, 32'ha5a5a59b, 32'h00000011};
  slac_bank slac_bank_inst (.*);
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 60) begin
      meas_busy <= 1'b0;
    end
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  function automatic logic [31:0] img(input int i);
    case (i)
      0: return {25'h0, rx_level_threshold_out, rx_resistor_trim_out};
      1: return {26'h0, rx_common_mode_term_en_out, rx_must_be_one_bit_out,
        rx_ac_offset_comp_en_out, rx_dc_offset_comp_en_out, rx_slow_level_detect_en_out, 1'b0};
      2: return {tx_force_idle_out, tx_nominal_supply_sel_out, tx_polarity_invert_out,
        tx_first_post_cursor_out, tx_second_post_cursor_out, tx_pre_cursor_out, 4'h0,
        tx_slew_coarse_half_out, tx_resistor_trim_out, tx_slew_fine_out};
      3: return {23'h0, tx_skew_adjust_out, tx_amplitude_level_out};
      4: return {28'h0, align_hysteresis_en_out, 1'b0, align_window_en_out, align_en_out};
      5: return {lane_reset_n_out, 12'h0, lane_en_out, 6'h0, equipment_loopback_en_out,
        facility_loopback_en_out, 2'h0, half_rate_en_out, quarter_rate_en_out, if_width_out, 4'h0};
      default: return {13'h0, pll_rotation_en_out, 2'h0, pll_fsm_control_word_out, pll_fsm_en_out,
        4'h0, pll_rotation_direction_out, pll_rotation_frequency_out, 1'b0};
    endcase
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wr_en_in <= 1'b1;
    wr_data_in <= d;
    @(posedge clk_sys_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    addr_in <= a;
    @(posedge clk_sys_in);
    #1 got = rd_data_out;
  endtask
  task automatic chk(input int i, input logic [31:0] d);
    rd(8'(4 * i + 4));
    cmp(got, d & msk[i]);
    cmp(img(i), d & omsk[i]);
  endtask
  task automatic complete_run();
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 7; i++) begin
        chk(i, dflt[i]);
      end
      while (meas_busy) begin
        @(posedge clk_sys_in);
      end
      wr(slac_pkg::SLAC_OFS_RX0, {28'h0, MEAS_CODE});
      chk(0, {28'h0, MEAS_CODE});
      wr(slac_pkg::SLAC_OFS_TX0, {24'h0, MEAS_CODE, 4'h0});
      chk(2, {24'h0, MEAS_CODE, 4'h0});
      wr(slac_pkg::SLAC_OFS_RX1, 32'h0000_0012);
      chk(1, 32'h0000_0012);
      for (int j = 0; j < 4; j++) begin
        for (int i = 0; i < 7; i++) begin
          wr(8'(4 * i + 4), pat[j]);
          chk(i, pat[j]);
        end
      end
      wr(8'h00, 32'hffffffff);
      rd(8'h00);
      cmp(got, 32'h0);
      wr(8'h20, 32'hffffffff);
      rd(8'h20);
      cmp(got, 32'h0);
      chk(6, 32'h00000010);
      @(posedge clk_sys_in);
      reset_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      reset_in <= 1'b0;
    end
    complete_run();
  end
endmodule // tb_slac_bank
`default_nettype wire
